// ### core/sprmx_pkg.sv
// Package of constants and types for the system pin remap and interrupt line select block
package sprmx_pkg;
   localparam logic [31:0] SPRMX_BASE_ADDR   = 32'h4001_0000;
   localparam logic [31:0] SPRMX_WINDOW_MASK = 32'hFFFF_FFF0;
   localparam logic [3:0]  OFS_PIN_PAIR      = 4'h0;
   localparam logic [3:0]  OFS_CONV_REMAP    = 4'h4;
   localparam logic [3:0]  OFS_SRC_SEL_LO    = 4'h8;
   localparam logic [3:0]  OFS_SRC_SEL_HI    = 4'hC;
   localparam int          POS_PIN_PAIR      = 4;
   localparam int          POS_CONV0_IN9     = 31;
   localparam int          POS_CONV0_IN8     = 30;
   localparam int          POS_CONV1_IN15    = 29;
   localparam int          POS_CONV1_IN14    = 28;
   localparam int          SEL_WIDTH         = 4;
   localparam int          SEL_FIELDS        = 4;
   localparam int          NUM_LINES         = 8;
   localparam int          NUM_PORTS         = 6;
   localparam logic [31:0] RESET_VALUE       = 32'h0000_0000;
   localparam logic [31:0] PIN_PAIR_MASK     = 32'h0000_0010;
   localparam logic [31:0] CONV_REMAP_MASK   = 32'hF000_0000;
   localparam logic [31:0] SRC_SEL_MASK      = 32'h0000_FFFF;
   localparam logic [2:0]  SEL_LAST_PORT     = 3'h5;

   // APB request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } sprmx_apb_req_t;

   // Routing controls derived from the registers
   typedef struct packed {
      logic pinPairRemap;
      logic conv0In9Remap;
      logic conv0In8Remap;
      logic conv1In15Remap;
      logic conv1In14Remap;
   } sprmx_remap_t;
endpackage

// ### core/sprmx_top.sv
// Pin remap and interrupt line source select block with APB register slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - Registers decode in a window at the fixed base address, each at its offset.
// - Registers take only full 32-bit word writes; partial strobes are refused.
// - All four registers reset to zero, so no remap and every line selects port A.
// - Bit 4 of the pin pair register moves port A pins 9/12 onto the shared pins of pins 10/11; here it only drives remapCtrl.pinPairRemap.
// - The pin pair bit is set only by software writes and cleared by software writes or by reset.
// - Bit 31 of the converter register moves converter 0 input 9 from port B pin 1 to port C pin 6.
// - Bit 30 moves converter 0 input 8 from port B pin 2 to port C pin 7.
// - Bit 29 moves converter 1 input 15 from port B pin 13 to port D pin 14.
// - Bit 28 moves converter 1 input 14 from port B pin 14 to port D pin 15.
// - Each selector ignores its top bit; codes 0 to 5 pick ports A to F, codes 6 and 7 are reserved.
// - The low source register holds selectors of lines 0 to 3 in successive nibbles, upper half reserved.
// - The high source register holds selectors of lines 4 to 7 in successive nibbles, upper half reserved.
module sprmx_top
   import sprmx_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire sprmx_apb_req_t       apbReq,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [NUM_LINES-1:0] portAIn,
   input  wire logic [NUM_LINES-1:0] portBIn,
   input  wire logic [NUM_LINES-1:0] portCIn,
   input  wire logic [NUM_LINES-1:0] portDIn,
   input  wire logic [NUM_LINES-1:0] portEIn,
   input  wire logic [NUM_LINES-1:0] portFIn,
   input  wire logic                 portBPin1,
   input  wire logic                 portBPin2,
   input  wire logic                 portBPin13,
   input  wire logic                 portBPin14,
   input  wire logic                 portCPin6,
   input  wire logic                 portCPin7,
   input  wire logic                 portDPin14,
   input  wire logic                 portDPin15,
   output logic                      converter0Input9,
   output logic                      converter0Input8,
   output logic                      converter1Input15,
   output logic                      converter1Input14,
   output sprmx_remap_t              remapCtrl,
   output logic [NUM_LINES-1:0]      externalInterruptLine
);

   logic [31:0]     pinPair_q;
   logic [31:0]     convRemap_q;
   logic [31:0]     srcSelLo_q;
   logic [31:0]     srcSelHi_q;
   logic [31:0]     prdata_q;
   logic            pslverr_q;

   wire logic       inWindow;
   wire logic       wordAccess;
   wire logic [3:0] offset;
   wire logic       hitPinPair;
   wire logic       hitConv;
   wire logic       hitLo;
   wire logic       hitHi;
   wire logic       hitAny;
   wire logic       accessDone;
   wire logic       wrOk;
   wire logic       errAccess;
   wire logic [31:0] rdMux;
   wire logic [NUM_LINES*SEL_WIDTH-1:0] selAll;

   // Address window decode
   // base window decode
   assign inWindow   = (apbReq.paddr & SPRMX_WINDOW_MASK) == SPRMX_BASE_ADDR;
   assign offset     = apbReq.paddr[3:0];
   assign hitPinPair = inWindow && (offset == OFS_PIN_PAIR);
   assign hitConv    = inWindow && (offset == OFS_CONV_REMAP);
   assign hitLo      = inWindow && (offset == OFS_SRC_SEL_LO);
   assign hitHi      = inWindow && (offset == OFS_SRC_SEL_HI);
   assign hitAny     = hitPinPair || hitConv || hitLo || hitHi;
   assign wordAccess = !apbReq.pwrite || (apbReq.pstrb == 4'hF);
   assign accessDone = apbReq.psel && apbReq.penable;
   assign wrOk       = accessDone && apbReq.pwrite && hitAny && wordAccess;
   assign errAccess  = !hitAny || !wordAccess;

   assign rdMux = hitPinPair ? (pinPair_q & PIN_PAIR_MASK) :
                  hitConv    ? (convRemap_q & CONV_REMAP_MASK) :
                  hitLo      ? (srcSelLo_q & SRC_SEL_MASK) :
                  hitHi      ? (srcSelHi_q & SRC_SEL_MASK) :
                  RESET_VALUE;

   // Zero wait state slave
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pinPair_q   <= RESET_VALUE;
         convRemap_q <= RESET_VALUE;
         srcSelLo_q  <= RESET_VALUE;
         srcSelHi_q  <= RESET_VALUE;
      end
      else if (wrOk)
      begin
         if (hitPinPair)
            pinPair_q <= apbReq.pwdata & PIN_PAIR_MASK;
         if (hitConv)
            convRemap_q <= apbReq.pwdata & CONV_REMAP_MASK;
         if (hitLo)
            srcSelLo_q <= apbReq.pwdata & SRC_SEL_MASK;
         if (hitHi)
            srcSelHi_q <= apbReq.pwdata & SRC_SEL_MASK;
      end
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata_q  <= RESET_VALUE;
         pslverr_q <= 1'b0;
      end
      else if (apbReq.psel && !apbReq.penable)
      begin
         prdata_q  <= apbReq.pwrite ? RESET_VALUE : rdMux;
         pslverr_q <= errAccess;
      end
   end

   // Remap controls
   // pin pair remap bit
   assign remapCtrl.pinPairRemap   = pinPair_q[POS_PIN_PAIR];
   assign remapCtrl.conv0In9Remap  = convRemap_q[POS_CONV0_IN9];
   assign remapCtrl.conv0In8Remap  = convRemap_q[POS_CONV0_IN8];
   assign remapCtrl.conv1In15Remap = convRemap_q[POS_CONV1_IN15];
   assign remapCtrl.conv1In14Remap = convRemap_q[POS_CONV1_IN14];

   assign converter0Input9  = remapCtrl.conv0In9Remap ? portCPin6 : portBPin1;
   assign converter0Input8  = remapCtrl.conv0In8Remap ? portCPin7 : portBPin2;
   assign converter1Input15 = remapCtrl.conv1In15Remap ? portDPin14 : portBPin13;
   assign converter1Input14 = remapCtrl.conv1In14Remap ? portDPin15 : portBPin14;

   assign selAll = {srcSelHi_q[SEL_FIELDS*SEL_WIDTH-1:0], srcSelLo_q[SEL_FIELDS*SEL_WIDTH-1:0]};

   // Port select for one line, top bit ignored
   function automatic logic pick_port(input logic [2:0] code, input logic [NUM_PORTS-1:0] pins);
      logic result;
      result = 1'b0;
      case (code)
         3'h0:    result = pins[0];
         3'h1:    result = pins[1];
         3'h2:    result = pins[2];
         3'h3:    result = pins[3];
         3'h4:    result = pins[4];
         3'h5:    result = pins[5];
         default: result = 1'b0;
      endcase
      return result;
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINES; gi++)
      begin : g_line
         wire logic [2:0]           code;
         wire logic [NUM_PORTS-1:0] pins;
         assign pins = {portFIn[gi], portEIn[gi], portDIn[gi], portCIn[gi], portBIn[gi], portAIn[gi]};
         assign code = selAll[gi*SEL_WIDTH +: 3];
         assign externalInterruptLine[gi] = pick_port(code, pins);

         a_line_follows: assert property (@(posedge clk) disable iff (!rstn)
            (code <= SEL_LAST_PORT) |-> externalInterruptLine[gi] == pins[code])
            else $error("interrupt line does not follow selected pin");
         a_reserved_low: assert property (@(posedge clk) disable iff (!rstn)
            (code > SEL_LAST_PORT) |-> !externalInterruptLine[gi])
            else $error("reserved selector drives interrupt line");
      end
   endgenerate

   a_partial_refused: assert property (@(posedge clk) disable iff (!rstn)
      (accessDone && apbReq.pwrite && apbReq.pstrb != 4'hF) |=> $stable(pinPair_q) && $stable(convRemap_q)
      && $stable(srcSelLo_q) && $stable(srcSelHi_q))
      else $error("partial write changed a register");
   a_unmapped_err: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && !inWindow) |=> pslverr)
      else $error("unmapped access without error");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
      (pinPair_q & ~PIN_PAIR_MASK) == RESET_VALUE && (srcSelLo_q & ~SRC_SEL_MASK) == RESET_VALUE
      && (convRemap_q & ~CONV_REMAP_MASK) == RESET_VALUE && (srcSelHi_q & ~SRC_SEL_MASK) == RESET_VALUE)
      else $error("reserved bits stored");
   a_pinpair_write: assert property (@(posedge clk) disable iff (!rstn)
      (wrOk && hitPinPair) |=> remapCtrl.pinPairRemap == $past(apbReq.pwdata[POS_PIN_PAIR]))
      else $error("pin pair bit did not take write");
   a_pinpair_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wrOk && hitPinPair) |=> $stable(remapCtrl.pinPairRemap))
      else $error("pin pair bit changed without write");
   a_conv0_in9: assert property (@(posedge clk) disable iff (!rstn)
      converter0Input9 == (convRemap_q[POS_CONV0_IN9] ? portCPin6 : portBPin1))
      else $error("converter 0 input 9 routed wrong");
   a_conv1_in14: assert property (@(posedge clk) disable iff (!rstn)
      converter1Input14 == (convRemap_q[POS_CONV1_IN14] ? portDPin15 : portBPin14))
      else $error("converter 1 input 14 routed wrong");
   a_lo_readback: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitLo)
      |=> prdata == $past(srcSelLo_q & SRC_SEL_MASK))
      else $error("low selector read back wrong");
   a_conv0_in8: assert property (@(posedge clk) disable iff (!rstn)
      converter0Input8 == (convRemap_q[POS_CONV0_IN8] ? portCPin7 : portBPin2))
      else $error("converter 0 input 8 routed wrong");
   a_conv1_in15: assert property (@(posedge clk) disable iff (!rstn)
      converter1Input15 == (convRemap_q[POS_CONV1_IN15] ? portDPin14 : portBPin13))
      else $error("converter 1 input 15 routed wrong");

   // Register read back
   // high selector read back
   a_hi_readback: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitHi)
      |=> prdata == $past(srcSelHi_q & SRC_SEL_MASK))
      else $error("high selector read back wrong");
   a_pinpair_readback: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitPinPair)
      |=> prdata == $past(pinPair_q & PIN_PAIR_MASK))
      else $error("pin pair register read back wrong");
   a_conv_readback: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitConv)
      |=> prdata == $past(convRemap_q & CONV_REMAP_MASK))
      else $error("converter register read back wrong");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && !apbReq.pwrite && !hitAny)
      |=> prdata == RESET_VALUE)
      else $error("unmapped read returned data");
   a_write_rd_zero: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && apbReq.pwrite) |=> prdata == RESET_VALUE)
      else $error("write transfer returned read data");

   // Error response
   // partial write flagged
   a_partial_err: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && apbReq.pwrite && apbReq.pstrb != 4'hF) |=> pslverr)
      else $error("partial write without error");
   a_mapped_ok: assert property (@(posedge clk) disable iff (!rstn)
      (apbReq.psel && !apbReq.penable && hitAny && wordAccess) |=> !pslverr)
      else $error("mapped word access flagged as error");
   a_err_stands: assert property (@(posedge clk) disable iff (!rstn)
      !(apbReq.psel && !apbReq.penable) |=> $stable(pslverr))
      else $error("error response changed outside setup");
   a_rdata_stands: assert property (@(posedge clk) disable iff (!rstn)
      !(apbReq.psel && !apbReq.penable) |=> $stable(prdata))
      else $error("read data changed outside setup");
   a_ready_high: assert property (@(posedge clk) disable iff (!rstn)
      pready)
      else $error("ready not high");

   // Register updates
   // converter register takes write
   a_conv_write: assert property (@(posedge clk) disable iff (!rstn)
      (wrOk && hitConv) |=> convRemap_q == $past(apbReq.pwdata & CONV_REMAP_MASK))
      else $error("converter register did not take write");
   a_lo_write: assert property (@(posedge clk) disable iff (!rstn)
      (wrOk && hitLo) |=> srcSelLo_q == $past(apbReq.pwdata & SRC_SEL_MASK))
      else $error("low selector did not take write");
   a_hi_write: assert property (@(posedge clk) disable iff (!rstn)
      (wrOk && hitHi) |=> srcSelHi_q == $past(apbReq.pwdata & SRC_SEL_MASK))
      else $error("high selector did not take write");
   a_conv_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wrOk && hitConv) |=> $stable(convRemap_q))
      else $error("converter register changed without write");
   a_lo_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wrOk && hitLo) |=> $stable(srcSelLo_q))
      else $error("low selector changed without write");
   a_hi_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wrOk && hitHi) |=> $stable(srcSelHi_q))
      else $error("high selector changed without write");
   a_unmapped_drop: assert property (@(posedge clk) disable iff (!rstn)
      (accessDone && apbReq.pwrite && !hitAny) |=> $stable(pinPair_q) && $stable(convRemap_q)
      && $stable(srcSelLo_q) && $stable(srcSelHi_q))
      else $error("unmapped write changed a register");
   a_read_no_change: assert property (@(posedge clk) disable iff (!rstn)
      (accessDone && !apbReq.pwrite) |=> $stable(pinPair_q) && $stable(convRemap_q)
      && $stable(srcSelLo_q) && $stable(srcSelHi_q))
      else $error("read changed a register");

   // Reset state
   // registers clear in reset
   a_reset_clear: assert property (@(posedge clk)
      !rstn ##1 !rstn |-> pinPair_q == RESET_VALUE && convRemap_q == RESET_VALUE
      && srcSelLo_q == RESET_VALUE && srcSelHi_q == RESET_VALUE)
      else $error("register not cleared by reset");
   a_reset_bus: assert property (@(posedge clk)
      !rstn ##1 !rstn |-> prdata == RESET_VALUE && !pslverr)
      else $error("bus outputs not cleared by reset");
   // lines follow port A in reset
   a_reset_lines: assert property (@(posedge clk)
      !rstn ##1 !rstn |-> externalInterruptLine == portAIn)
      else $error("interrupt lines not on port A in reset");
   // converters on port B in reset
   a_reset_conv: assert property (@(posedge clk)
      !rstn ##1 !rstn |-> converter0Input9 == portBPin1 && converter0Input8 == portBPin2
      && converter1Input15 == portBPin13 && converter1Input14 == portBPin14)
      else $error("converter inputs not on port B in reset");

endmodule // sprmx_top

// ### sim/sprmx_top_bench.sv
// Self-checking bench for the pin remap and interrupt line select block
`timescale 1ns/1ps
module sprmx_top_bench;
   import sprmx_pkg::*;
   localparam logic [31:0] MASKS [4] = '{PIN_PAIR_MASK, CONV_REMAP_MASK, SRC_SEL_MASK, SRC_SEL_MASK};
   localparam logic [31:0] OFFS [7]  = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'hFFFF_FFFC, 32'h100};
   logic           clk         = 1'b0;
   logic           rstn        = 1'b0;
   sprmx_apb_req_t apbReq      = '0;
   logic [7:0]     portIn [6]  = '{default: 8'h00};
   logic [7:0]     convPin     = 8'h00;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic [3:0]     convOut;
   sprmx_remap_t   remapCtrl;
   logic [7:0]     irqLine;
   logic [31:0]    mdl [4]     = '{default: 32'h0};
   integer         seed        = 67;
   int             errorCnt    = 0;
   int             numChecks   = 0;

   always #5 clk = ~clk;

   sprmx_top dut (
      .clk(clk), .rstn(rstn), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .portAIn(portIn[0]), .portBIn(portIn[1]), .portCIn(portIn[2]), .portDIn(portIn[3]),
      .portEIn(portIn[4]), .portFIn(portIn[5]),
      .portBPin1(convPin[0]), .portBPin2(convPin[1]), .portBPin13(convPin[2]), .portBPin14(convPin[3]),
      .portCPin6(convPin[4]), .portCPin7(convPin[5]), .portDPin14(convPin[6]), .portDPin15(convPin[7]),
      .converter0Input9(convOut[3]), .converter0Input8(convOut[2]),
      .converter1Input15(convOut[1]), .converter1Input14(convOut[0]),
      .remapCtrl(remapCtrl), .externalInterruptLine(irqLine)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wrapUp;
      if (errorCnt == 0 && numChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // One APB transfer, checked against the model
   task automatic busOp(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic        hit;
      logic        err;
      logic        errSeen;
      logic [31:0] rd;
      int          i;
      hit = (a & SPRMX_WINDOW_MASK) == SPRMX_BASE_ADDR;
      i = a[3:2];
      err = !hit || (w && s != 4'hF);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      apbReq <= '0;
      chk({31'h0, errSeen}, {31'h0, err});
      if (!w)
         chk(rd, hit ? mdl[i] : 32'h0);
      else if (!err)
         mdl[i] = d & MASKS[i];
      @(posedge clk);
   endtask

   // New pin levels, then compare every routed output
   task automatic shake;
      logic [7:0] expLine;
      logic [2:0] code;
      for (int p = 0; p < 6; p++)
         portIn[p] <= 8'($random(seed));
      convPin <= 8'($random(seed));
      @(negedge clk);
      for (int n = 0; n < 8; n++)
      begin
         code = n < 4 ? mdl[2][4*n +: 3] : mdl[3][4*(n-4) +: 3];
         expLine[n] = code < 3'h6 ? portIn[code][n] : 1'b0;
      end
      chk({24'h0, irqLine}, {24'h0, expLine});
      chk({28'h0, convOut}, {28'h0, mdl[1][31] ? convPin[4] : convPin[0], mdl[1][30] ? convPin[5] : convPin[1],
          mdl[1][29] ? convPin[6] : convPin[2], mdl[1][28] ? convPin[7] : convPin[3]});
      chk(32'(remapCtrl), {27'h0, mdl[0][4], mdl[1][31:28]});
      @(posedge clk);
   endtask

   initial
   begin
      logic [31:0] r;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      shake;
      for (int i = 0; i < 4; i++)
         busOp(1'b0, SPRMX_BASE_ADDR + 32'(4*i), 32'h0, 4'h0);
      // Every selector code on every line, with reserved bits left at zero
      for (int c = 0; c < 16; c++)
      begin
         logic [3:0] k;
         k = 4'(c);
         busOp(1'b1, SPRMX_BASE_ADDR + 32'h8, {16'h0, {4{k}}}, 4'hF);
         busOp(1'b1, SPRMX_BASE_ADDR + 32'hC, {16'h0, {4{~k}}}, 4'hF);
         busOp(1'b1, SPRMX_BASE_ADDR + 32'h4, {k, 28'h0}, 4'hF);
         busOp(1'b1, SPRMX_BASE_ADDR, {27'h0, k[0], 4'h0}, 4'hF);
         repeat (2) shake;
         for (int i = 0; i < 4; i++)
            busOp(1'b0, SPRMX_BASE_ADDR + 32'(4*i), 32'h0, 4'h0);
      end
      // Mid-run reset clears every register
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      mdl = '{default: 32'h0};
      @(posedge clk);
      shake;
      for (int i = 0; i < 4; i++)
         busOp(1'b0, SPRMX_BASE_ADDR + 32'(4*i), 32'h0, 4'h0);
      // Random traffic with partial strobes and unmapped addresses
      repeat (80)
      begin
         r = $random(seed);
         busOp(r[0], SPRMX_BASE_ADDR + OFFS[r[10:8] % 7], $random(seed) & MASKS[2'(r[10:8] % 7)], r[1] ? 4'hF : r[7:4]);
         shake;
      end
      wrapUp;
   end

   initial
   begin
      #100000;
      errorCnt++;
      wrapUp;
   end
endmodule // sprmx_top_bench
